/* rsi_pkg.sv */
// Package with the register map, field positions and reset values of the reset state initialiser.
`default_nettype none
package rsi_pkg;
    // APB byte addresses of the registers.
    localparam logic [7:0] OFS_STATUS      = 8'h00;
    localparam logic [7:0] OFS_WDOG_CTRL   = 8'h04;
    localparam logic [7:0] OFS_INT_ENABLE  = 8'h08;
    localparam logic [7:0] OFS_TIMER_CTRL  = 8'h0C;
    localparam logic [7:0] OFS_PORT_BASE   = 8'h10;
    localparam logic [7:0] OFS_PORT_STRIDE = 8'h10;
    localparam logic [7:0] OFS_PORT_DATA   = 8'h00;
    localparam logic [7:0] OFS_PORT_DIR    = 8'h04;
    localparam logic [7:0] OFS_PORT_PULLUP = 8'h08;
    localparam logic [7:0] OFS_ACCUM       = 8'h44;
    localparam logic [7:0] OFS_TABLE_PTR   = 8'h48;
    localparam logic [7:0] OFS_TABLE_HIGH  = 8'h4C;
    localparam logic [7:0] OFS_PC_LOW      = 8'h50;
    localparam logic [7:0] OFS_STACK_PTR   = 8'h54;
    localparam logic [7:0] OFS_WDOG_COUNT  = 8'h58;
    localparam logic [7:0] OFS_TBASE_COUNT = 8'h5C;
    localparam logic [7:0] OFS_RESET_CAUSE = 8'h60;

    // Bit positions of the two flags in the status register.
    localparam int BIT_POWERDOWN = 4;
    localparam int BIT_TIMEOUT   = 5;

    // Watchdog control: enable field in bits 7..3.
    localparam int          WDOG_EN_LSB   = 3;
    localparam logic [4:0]  WDOG_EN_CODE0 = 5'h0A;
    localparam logic [4:0]  WDOG_EN_CODE1 = 5'h15;

    // Reset values.
    localparam logic [7:0] RST_WDOG_CTRL   = 8'h53;
    localparam logic [7:0] RST_PORT_DATA   = 8'hFF;
    localparam logic [7:0] RST_PORT_DIR    = 8'hFF;
    localparam logic [7:0] RST_PORT_PULLUP = 8'h00;
    localparam logic [7:0] RST_INT_ENABLE  = 8'h00;
    localparam logic [7:0] RST_TIMER_CTRL  = 8'h00;
    localparam logic [7:0] RST_DATA_REG    = 8'h00;
    localparam logic [7:0] RST_PC_LOW      = 8'h00;
    localparam logic [3:0] RST_STACK_TOP   = 4'h0;
    localparam logic [3:0] RST_STACK_CLEAR = 4'h0;

    // Reset cause codes held in the cause register.
    typedef enum logic [2:0]
    {
        CAUSE_NONE,
        CAUSE_POWER_ON,
        CAUSE_SUPPLY_DROP,
        CAUSE_WDOG_RUN,
        CAUSE_WDOG_SLEEP
    } rsi_cause_t;
endpackage
`default_nettype wire

/* rsi_counter.sv */
// Free running counter with synchronous clear and count enable.
`default_nettype none
module rsi_counter
#(
    parameter int WIDTH = 16
)
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic             clear,
    input  wire logic             enable,
    output logic [WIDTH-1:0]      count
);
    // Clear takes priority so a reset event always starts the count from zero.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || clear)
        begin
            count <= '0;
        end
        else if (enable)
        begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire

/* rsi_reset_state_initialiser.sv */
// Reset state initialiser: reset cause flags and per reset type register initialisation.
//
// Design decisions made here: the register offsets and the APB slave port.
`default_nettype none
// Notes on behaviour
// R1: Watchdog timeout in sleep/idle zeroes PC and SP, sets both flags, nothing else.
// R2: Timeout and powerdown flags live in status; sleep entry and watchdog update them.
// R3: Power-on reset clears both timeout and powerdown flags.
// R4: Supply-drop reset in fast or slow mode keeps both flags unchanged.
// R5: Watchdog reset in fast or slow mode sets timeout, keeps powerdown.
// R6: Power-on reset zeroes PC and puts SP at top of stack.
// R7: Power-on reset disables every interrupt source.
// R8: Power-on clears watchdog and time base counters, loads watchdog control default.
// R9: Power-on reset switches all timer modules off.
// R10: Port data and direction load all ones, pull-ups zero, on power-on and run-mode watchdog.
// R11: Watchdog run reset reloads controls; accumulator and table registers keep values.
// R12: Watchdog timeout in normal operation sets timeout and resets all but the accumulator and table registers.
module rsi_reset_state_initialiser
#(
    parameter int NUM_PORTS   = 3,
    parameter int WDOG_WIDTH  = 18,
    parameter int TBASE_WIDTH = 16
)
(
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   sleep_idle,
    input  wire logic                   sleep_entry,
    input  wire logic                   supply_drop_reset,
    input  wire logic                   wdog_timeout,
    input  wire logic                   pc_advance,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic                        timeout_flag,
    output logic                        powerdown_flag,
    output logic [7:0]                  watchdog_control,
    output logic                        wdog_enabled,
    output logic [7:0]                  int_enable,
    output logic [7:0]                  timer_control,
    output logic [8*NUM_PORTS-1:0]      port_data,
    output logic [8*NUM_PORTS-1:0]      port_dir,
    output logic [8*NUM_PORTS-1:0]      port_pullup,
    output logic [7:0]                  program_counter_low,
    output logic [3:0]                  stack_pointer,
    output logic                        core_restart
);
    logic                   ev_power_on;
    logic                   ev_supply;
    logic                   ev_wdog_run;
    logic                   ev_wdog_sleep;
    logic                   full_init;
    logic                   wr_access;
    logic                   wr_lane0;
    logic                   addr_hit;
    logic [31:0]            rd_word;
    logic [7:0]             accumulator;
    logic [7:0]             table_pointer;
    logic [7:0]             table_high_byte;
    logic [WDOG_WIDTH-1:0]  wdog_count;
    logic [TBASE_WIDTH-1:0] tbase_count;
    logic [7:0]             port_rd   [NUM_PORTS];
    logic [NUM_PORTS-1:0]   port_hit;
    rsi_pkg::rsi_cause_t    last_cause;

    // Supply-drop detection is off in sleep or idle, so only an active mode drop counts.
    assign ev_power_on   = sys_rst;
    assign ev_supply     = supply_drop_reset && !sleep_idle;
    assign ev_wdog_run   = wdog_timeout && !sleep_idle;
    assign ev_wdog_sleep = wdog_timeout && sleep_idle;
    assign full_init     = ev_supply || ev_wdog_run; // R12

    assign wr_access = psel && penable && pwrite;
    assign wr_lane0  = wr_access && pstrb[0];

    assign wdog_enabled =
        (watchdog_control[7:rsi_pkg::WDOG_EN_LSB] == rsi_pkg::WDOG_EN_CODE0) ||
        (watchdog_control[7:rsi_pkg::WDOG_EN_LSB] == rsi_pkg::WDOG_EN_CODE1);

    // Status flags; software only reads them.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on)
        begin
            timeout_flag   <= 1'b0; // R3
            powerdown_flag <= 1'b0; // R3
        end
        else if (ev_wdog_sleep)
        begin
            timeout_flag   <= 1'b1; // R1
            powerdown_flag <= 1'b1; // R1
        end
        else if (ev_wdog_run)
        begin
            timeout_flag   <= 1'b1; // R5
        end
        else if (ev_supply)
        begin
            timeout_flag   <= timeout_flag;   // R4
            powerdown_flag <= powerdown_flag; // R4
        end
        else if (sleep_entry)
        begin
            timeout_flag   <= 1'b0; // R2
            powerdown_flag <= 1'b1; // R2
        end
    end

    // Watchdog control register.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on || full_init)
        begin
            watchdog_control <= rsi_pkg::RST_WDOG_CTRL; // R8
        end
        else if (!ev_wdog_sleep && wr_lane0 && paddr == rsi_pkg::OFS_WDOG_CTRL)
        begin
            watchdog_control <= pwdata[7:0];
        end
    end

    // Interrupt enables.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on || full_init)
        begin
            int_enable <= rsi_pkg::RST_INT_ENABLE; // R7
        end
        else if (!ev_wdog_sleep && wr_lane0 && paddr == rsi_pkg::OFS_INT_ENABLE)
        begin
            int_enable <= pwdata[7:0];
        end
    end

    // Timer module control.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on || full_init)
        begin
            timer_control <= rsi_pkg::RST_TIMER_CTRL; // R9
        end
        else if (!ev_wdog_sleep && wr_lane0 && paddr == rsi_pkg::OFS_TIMER_CTRL)
        begin
            timer_control <= pwdata[7:0];
        end
    end

    // Port registers, one set per port.
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++)
        begin : g_port
            localparam logic [7:0] BASE =
                8'(rsi_pkg::OFS_PORT_BASE + gp * rsi_pkg::OFS_PORT_STRIDE);
            logic [7:0] data_q;
            logic [7:0] dir_q;
            logic [7:0] pull_q;
            logic       wr_ok;

            assign wr_ok = wr_lane0 && !ev_wdog_sleep;

            always_ff @(posedge ref_clk)
            begin
                if (ev_power_on || full_init)
                begin
                    data_q <= rsi_pkg::RST_PORT_DATA;   // R10
                    dir_q  <= rsi_pkg::RST_PORT_DIR;    // R10
                    pull_q <= rsi_pkg::RST_PORT_PULLUP; // R10
                end
                else if (wr_ok)
                begin
                    if (paddr == 8'(BASE + rsi_pkg::OFS_PORT_DATA))
                    begin
                        data_q <= pwdata[7:0];
                    end
                    if (paddr == 8'(BASE + rsi_pkg::OFS_PORT_DIR))
                    begin
                        dir_q <= pwdata[7:0];
                    end
                    if (paddr == 8'(BASE + rsi_pkg::OFS_PORT_PULLUP))
                    begin
                        pull_q <= pwdata[7:0];
                    end
                end
            end

            assign port_data[8*gp +: 8]   = data_q;
            assign port_dir[8*gp +: 8]    = dir_q;
            assign port_pullup[8*gp +: 8] = pull_q;

            always_comb
            begin
                port_rd[gp]  = 8'h00;
                port_hit[gp] = 1'b1;
                if (paddr == 8'(BASE + rsi_pkg::OFS_PORT_DATA))
                begin
                    port_rd[gp] = data_q;
                end
                else if (paddr == 8'(BASE + rsi_pkg::OFS_PORT_DIR))
                begin
                    port_rd[gp] = dir_q;
                end
                else if (paddr == 8'(BASE + rsi_pkg::OFS_PORT_PULLUP))
                begin
                    port_rd[gp] = pull_q;
                end
                else
                begin
                    port_hit[gp] = 1'b0;
                end
            end
        end
    endgenerate

    // Working registers survive every reset except power-on.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on)
        begin
            accumulator     <= rsi_pkg::RST_DATA_REG;
            table_pointer   <= rsi_pkg::RST_DATA_REG;
            table_high_byte <= rsi_pkg::RST_DATA_REG;
        end
        else if (wr_lane0 && !full_init && !ev_wdog_sleep) // R11
        begin
            if (paddr == rsi_pkg::OFS_ACCUM)
            begin
                accumulator <= pwdata[7:0];
            end
            if (paddr == rsi_pkg::OFS_TABLE_PTR)
            begin
                table_pointer <= pwdata[7:0];
            end
            if (paddr == rsi_pkg::OFS_TABLE_HIGH)
            begin
                table_high_byte <= pwdata[7:0];
            end
        end
    end

    // Program counter low byte.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on)
        begin
            program_counter_low <= rsi_pkg::RST_PC_LOW; // R6
        end
        else if (ev_wdog_sleep)
        begin
            program_counter_low <= rsi_pkg::RST_PC_LOW; // R1
        end
        else if (full_init)
        begin
            program_counter_low <= rsi_pkg::RST_PC_LOW; // R12
        end
        else if (wr_lane0 && paddr == rsi_pkg::OFS_PC_LOW)
        begin
            program_counter_low <= pwdata[7:0];
        end
        else if (pc_advance)
        begin
            program_counter_low <= program_counter_low + 8'h01;
        end
    end

    // Stack pointer.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on || full_init)
        begin
            stack_pointer <= rsi_pkg::RST_STACK_TOP; // R6
        end
        else if (ev_wdog_sleep)
        begin
            stack_pointer <= rsi_pkg::RST_STACK_CLEAR; // R1
        end
        else if (wr_lane0 && paddr == rsi_pkg::OFS_STACK_PTR)
        begin
            stack_pointer <= pwdata[3:0];
        end
    end

    // A timeout in sleep keeps counting state, since only PC, SP and the flags are touched there.
    rsi_counter
    #(
        .WIDTH   (WDOG_WIDTH)
    )
    u_wdog_counter
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clear   (full_init), // R8
        .enable  (wdog_enabled),
        .count   (wdog_count)
    );

    rsi_counter
    #(
        .WIDTH   (TBASE_WIDTH)
    )
    u_tbase_counter
    (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .clear   (full_init), // R8
        .enable  (1'b1),
        .count   (tbase_count)
    );

    // Cause of the most recent reset and the restart pulse for the core.
    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on)
        begin
            last_cause <= rsi_pkg::CAUSE_POWER_ON;
        end
        else if (ev_wdog_sleep)
        begin
            last_cause <= rsi_pkg::CAUSE_WDOG_SLEEP;
        end
        else if (ev_wdog_run)
        begin
            last_cause <= rsi_pkg::CAUSE_WDOG_RUN;
        end
        else if (ev_supply)
        begin
            last_cause <= rsi_pkg::CAUSE_SUPPLY_DROP;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (ev_power_on)
        begin
            core_restart <= 1'b0;
        end
        else
        begin
            core_restart <= full_init || ev_wdog_sleep;
        end
    end

    // Read decode; the access completes in its first access cycle.
    always_comb
    begin
        rd_word  = 32'h0000_0000;
        addr_hit = 1'b1;
        case (paddr)
            rsi_pkg::OFS_STATUS:
            begin
                rd_word[rsi_pkg::BIT_TIMEOUT]   = timeout_flag;   // R2
                rd_word[rsi_pkg::BIT_POWERDOWN] = powerdown_flag; // R2
            end
            rsi_pkg::OFS_WDOG_CTRL:   rd_word[7:0] = watchdog_control;
            rsi_pkg::OFS_INT_ENABLE:  rd_word[7:0] = int_enable;
            rsi_pkg::OFS_TIMER_CTRL:  rd_word[7:0] = timer_control;
            rsi_pkg::OFS_ACCUM:       rd_word[7:0] = accumulator;
            rsi_pkg::OFS_TABLE_PTR:   rd_word[7:0] = table_pointer;
            rsi_pkg::OFS_TABLE_HIGH:  rd_word[7:0] = table_high_byte;
            rsi_pkg::OFS_PC_LOW:      rd_word[7:0] = program_counter_low;
            rsi_pkg::OFS_STACK_PTR:   rd_word[3:0] = stack_pointer;
            rsi_pkg::OFS_WDOG_COUNT:  rd_word[WDOG_WIDTH-1:0] = wdog_count;
            rsi_pkg::OFS_TBASE_COUNT: rd_word[TBASE_WIDTH-1:0] = tbase_count;
            rsi_pkg::OFS_RESET_CAUSE: rd_word[2:0] = last_cause;
            default:
            begin
                addr_hit = 1'b0;
                for (int i = 0; i < NUM_PORTS; i++)
                begin
                    if (port_hit[i])
                    begin
                        rd_word[7:0] = port_rd[i];
                        addr_hit     = 1'b1;
                    end
                end
            end
        endcase
    end

    // Unmapped addresses answer with an error and read as zero.
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata  = (psel && !pwrite) ? rd_word : 32'h0000_0000;
endmodule
`default_nettype wire

/* rsi_reset_state_initialiser_chk.sv */
// Assertion checker for the reset state initialiser outputs.
`default_nettype none
module rsi_reset_state_initialiser_chk
#(
    parameter int NUM_PORTS = 3
)
(
    input wire logic                   ref_clk,
    input wire logic                   sys_rst,
    input wire logic                   sleep_idle,
    input wire logic                   sleep_entry,
    input wire logic                   supply_drop_reset,
    input wire logic                   wdog_timeout,
    input wire logic                   timeout_flag,
    input wire logic                   powerdown_flag,
    input wire logic [7:0]             watchdog_control,
    input wire logic [7:0]             int_enable,
    input wire logic [7:0]             timer_control,
    input wire logic [8*NUM_PORTS-1:0] port_data,
    input wire logic [8*NUM_PORTS-1:0] port_dir,
    input wire logic [8*NUM_PORTS-1:0] port_pullup,
    input wire logic [7:0]             program_counter_low,
    input wire logic [3:0]             stack_pointer,
    input wire logic                   core_restart
);
    default clocking cb @(posedge ref_clk);
    endclocking

    a_por_flags: assert property (sys_rst |=> !timeout_flag && !powerdown_flag)
        else $error("flags not cleared by power-on reset");
    a_por_pcsp: assert property (sys_rst |=> program_counter_low == 0 && stack_pointer == 0)
        else $error("pc or sp wrong after power-on reset");
    a_por_ctrl: assert property (sys_rst |=> int_enable == 0 && timer_control == 0
        && watchdog_control == 8'h53) else $error("controls wrong after power-on reset");
    a_por_ports: assert property (sys_rst |=> &port_data && &port_dir && port_pullup == 0)
        else $error("ports wrong after power-on reset");
    a_sleep_wdog_flags: assert property (disable iff (sys_rst) wdog_timeout && sleep_idle
        |=> timeout_flag && powerdown_flag && program_counter_low == 0 && stack_pointer == 0)
        else $error("sleep watchdog did not set flags or clear pc and sp");
    a_sleep_wdog_keep: assert property (disable iff (sys_rst) wdog_timeout && sleep_idle
        |=> $stable(int_enable) && $stable(port_dir) && $stable(watchdog_control))
        else $error("sleep watchdog disturbed other state");
    a_run_wdog_flags: assert property (disable iff (sys_rst) wdog_timeout && !sleep_idle
        |=> timeout_flag && powerdown_flag == $past(powerdown_flag))
        else $error("run watchdog flags wrong");
    a_run_wdog_init: assert property (disable iff (sys_rst) wdog_timeout && !sleep_idle
        |=> &port_dir && port_pullup == 0 && int_enable == 0 && watchdog_control == 8'h53)
        else $error("run watchdog did not initialise controls");
    a_supply_keep: assert property (disable iff (sys_rst) supply_drop_reset && !wdog_timeout
        |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("supply drop changed flags");
    a_flags_hold: assert property (disable iff (sys_rst) !wdog_timeout && !sleep_entry
        |=> $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("flags changed without cause");
    a_restart_follows: assert property (disable iff (sys_rst) wdog_timeout && !sleep_idle
        |-> ##[1:2] core_restart) else $error("no core restart after watchdog");
endmodule

bind rsi_reset_state_initialiser rsi_reset_state_initialiser_chk #(.NUM_PORTS(NUM_PORTS)) i_chk
(
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .sleep_idle(sleep_idle),
    .sleep_entry(sleep_entry),
    .supply_drop_reset(supply_drop_reset),
    .wdog_timeout(wdog_timeout),
    .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag),
    .watchdog_control(watchdog_control),
    .int_enable(int_enable),
    .timer_control(timer_control),
    .port_data(port_data),
    .port_dir(port_dir),
    .port_pullup(port_pullup),
    .program_counter_low(program_counter_low),
    .stack_pointer(stack_pointer),
    .core_restart(core_restart)
);
`default_nettype wire

/* rsi_reset_state_initialiser_test.sv */
// Self-checking testbench for the reset state initialiser.
`default_nettype none
module rsi_reset_state_initialiser_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, sys_rst, sleep_idle, sleep_entry, supply_drop_reset;
    logic        wdog_timeout, pc_advance, psel, penable, pwrite;
    logic        pready, pslverr, timeout_flag, powerdown_flag, wdog_enabled, core_restart, er;
    logic [7:0]  paddr, watchdog_control, int_enable, timer_control, program_counter_low;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, stack_pointer;
    logic [23:0] port_data, port_dir, port_pullup;
    int          bad_count, compares, restarts, r0;

    rsi_reset_state_initialiser i_dut
    (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .sleep_idle(sleep_idle),
        .sleep_entry(sleep_entry), .supply_drop_reset(supply_drop_reset),
        .wdog_timeout(wdog_timeout), .pc_advance(pc_advance), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .watchdog_control(watchdog_control), .wdog_enabled(wdog_enabled),
        .int_enable(int_enable), .timer_control(timer_control), .port_data(port_data),
        .port_dir(port_dir), .port_pullup(port_pullup),
        .program_counter_low(program_counter_low), .stack_pointer(stack_pointer),
        .core_restart(core_restart)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        if (core_restart === 1'b1)
            restarts++;

    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
        end
    endtask

    // Entered just after a rising edge; the request is held until pready is sampled.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps a following call from raising psel in the same step.
        @(posedge ref_clk);
    endtask

    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, rd, e);
    endtask

    // One-cycle event pulse; bits are sleep entry, supply drop, watchdog, pc advance.
    task automatic ev(input logic [3:0] m);
        {sleep_entry, supply_drop_reset, wdog_timeout, pc_advance} <= m;
        @(posedge ref_clk);
        {sleep_entry, supply_drop_reset, wdog_timeout, pc_advance} <= 4'h0;
        @(posedge ref_clk);
    endtask

    task automatic dirty();
        apb(1'b1, rsi_pkg::OFS_INT_ENABLE, 32'hA5);
        apb(1'b1, rsi_pkg::OFS_TIMER_CTRL, 32'h3C);
        apb(1'b1, rsi_pkg::OFS_WDOG_CTRL, 32'hAC);
        apb(1'b1, rsi_pkg::OFS_STACK_PTR, 32'h5);
        apb(1'b1, rsi_pkg::OFS_ACCUM, 32'h5A);
        for (int n = 0; n < 3; n++)
        begin
            apb(1'b1, 8'h10 + 8'(n * 16), 32'h12);
            apb(1'b1, 8'h14 + 8'(n * 16), 32'h34);
            apb(1'b1, 8'h18 + 8'(n * 16), 32'h56);
        end
        ev(4'h1);
    endtask

    task automatic chkinit();
        chk("int_enable", int_enable, 32'h0);
        chk("timer_control", timer_control, 32'h0);
        chk("watchdog_control", watchdog_control, 32'h53);
        chk("wdog_enabled", wdog_enabled, 32'h1);
        chk("port_data", port_data, 32'hFFFFFF);
        chk("port_dir", port_dir, 32'hFFFFFF);
        chk("port_pullup", port_pullup, 32'h0);
    endtask

    task automatic t_por();
        dirty();
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        chkinit();
        chk("pc", program_counter_low, 32'h0);
        chk("sp", stack_pointer, 32'(rsi_pkg::RST_STACK_TOP));
        chk("flags", {timeout_flag, powerdown_flag}, 32'h0);
        // Both counters run from the release edge, so each read shows the edges since then.
        rchk("wdog_count", rsi_pkg::OFS_WDOG_COUNT, 32'h2);
        rchk("tbase_count", rsi_pkg::OFS_TBASE_COUNT, 32'h5);
        apb(1'b1, rsi_pkg::OFS_STATUS, 32'h30);
        rchk("status", rsi_pkg::OFS_STATUS, 32'h0);
        apb(1'b0, 8'h7C, 32'h0);
        chk("unmapped_err", er, 32'h1);
        $display("test power-on done");
    endtask

    task automatic t_wrun();
        dirty();
        r0 = restarts;
        ev(4'h2);
        chk("flags_run0", {timeout_flag, powerdown_flag}, 32'h2);
        chkinit();
        rchk("accum_kept", rsi_pkg::OFS_ACCUM, 32'h5A);
        chk("restart", restarts - r0, 32'h1);
        ev(4'h8);
        chk("flags_sleep", {timeout_flag, powerdown_flag}, 32'h1);
        ev(4'h2);
        chk("flags_run1", {timeout_flag, powerdown_flag}, 32'h3);
        $display("test watchdog run done");
    endtask

    task automatic t_wsleep();
        // A power-on reset first clears both flags so that setting them is visible.
        sys_rst <= 1'b1;
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        dirty();
        sleep_idle <= 1'b1;
        ev(4'h2);
        chk("pc", program_counter_low, 32'h0);
        chk("sp", stack_pointer, 32'h0);
        chk("flags", {timeout_flag, powerdown_flag}, 32'h3);
        chk("int_kept", int_enable, 32'hA5);
        chk("timer_kept", timer_control, 32'h3C);
        chk("wdc_kept", watchdog_control, 32'hAC);
        chk("dir_kept", port_dir, 32'h343434);
        rchk("accum_kept", rsi_pkg::OFS_ACCUM, 32'h5A);
        sleep_idle <= 1'b0;
        $display("test watchdog sleep done");
    endtask

    task automatic t_supply();
        // Sleep entry leaves the flags unequal, so a kept value differs from a set one.
        ev(4'h8);
        ev(4'h4);
        chk("flags", {timeout_flag, powerdown_flag}, 32'h1);
        chkinit();
        rchk("cause", rsi_pkg::OFS_RESET_CAUSE, 32'h2);
        $display("test supply drop done");
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // The tests need well under a thousand cycles; five thousand means a hang.
    initial
    begin
        #500000;
        bad_count++;
        final_report();
    end

    initial
    begin
        {sys_rst, sleep_idle, sleep_entry, supply_drop_reset} = 4'h8;
        {wdog_timeout, pc_advance, psel, penable, pwrite} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        t_por();
        t_wrun();
        t_wsleep();
        t_supply();
        final_report();
    end
endmodule
`default_nettype wire
